// >>> hw/safety_frame_node.sv
// Sequencer node: channel, slot timing, join/scan, relay with age, checked receive
//
// Overview of operation
// - Channel index plus ten gives radio channel
// - Only accept members with same program
// - Bad checksum packets are discarded entirely
// - Stale source forces its signals to zero
// - Transmit in ascending node order per frame
// - Frame period follows member count table
// - Response bounded by selected long/short timeout
// - No acknowledgement and no retransmission
// - Relay heard member data while it is fresh
// - Every item carries its age
// - Node one transmits without scanning, first at the start of the second frame after start-up
// - Other nodes start scanning all channels
// - Join on direct or relayed node-one data
// - Lost node one returns members to scanning
// - Lost member other than node one only affects its own signals
// - Lost link latches safe until restart
// - Sixteen radio signals per node
// - Apply one packet atomically or not
`timescale 1ns/1ps
`include "radio_frame_cfg.svh"
module safety_frame_node
   import radio_frame_pkg::*;
#(
   parameter int unsigned CYC_PER_US     = `REF_CLK_MHZ,
   parameter int unsigned FRAME_US [15]  = `FRAME_US_TABLE,
   parameter int unsigned SCAN_DWELL_CYC = `SCAN_DWELL_US * `REF_CLK_MHZ
)
(
   // Clock and reset
   input  wire logic                    REF_CLK,
   input  wire logic                    RST_B,
   // Configuration
   input  wire logic [3:0]              NODE_IDX,
   input  wire logic [4:0]              MEMBERS,
   input  wire logic [4:0]              CHANNEL,
   input  wire logic [15:0]             PROG_ID,
   input  wire logic [15:0][31:0]       MEMBER_SERIAL,
   input  wire logic                    SHORT_TMO,
   // Own signals and restart
   input  wire logic [15:0]             OWN_SIG,
   input  wire logic                    RESTART,
   // Received safety state
   output logic      [15:0][15:0]       RX_SIG,
   output logic      [15:0]             RX_OK,
   output logic                         JOINED,
   // Air
   radio_air_if.node                    air
);

   link_st_t          st_r;
   tx_st_t            tx_st_r;
   logic [3:0]        tx_idx_r;
   logic [15:0]       own_r;
   logic [23:0]       cnt_r;
   logic [3:0]        slot_r;
   logic [23:0]       slot_len [15];
   logic [23:0]       slot_cur;
   logic              frame_tick;
   logic [31:0]       scan_cnt_r;
   logic [3:0]        scan_ch_r;
   logic [7:0]        tmo;
   logic [15:0][15:0] tbl_sig_r;
   logic [15:0][7:0]  tbl_age_r;
   logic [15:0]       tbl_vld_r;
   logic [15:0][15:0] stg_sig_r;
   logic [15:0][7:0]  stg_age_r;
   logic [15:0]       stg_vld_r;
   logic [15:0]       fresh;
   logic [15:0]       fresh_r;
   logic [15:0]       lost_r;
   logic [1:0]        rx_ph_r;
   logic              rx_ok_r;
   logic [3:0]        rx_src_r;
   logic              commit_r;
   logic              rx_hit;
   logic [31:0]       rx_crc;
   logic [31:0]       tx_crc;
   logic              tx_load;
   logic              tx_sop;
   logic              tx_eop;
   logic [31:0]       tx_word;
   logic              join_ev;
   logic              drop_ev;
   logic              tx_go;
   entry_t            ent;

   // Slot length per member count; rounding down keeps a frame within its period
   for (genvar g = 0; g < 15; g++)
   begin : g_slot
      assign slot_len[g] = 24'(FRAME_US[g] * CYC_PER_US / (g + 2));
   end
   assign slot_cur   = slot_len[4'(MEMBERS - 5'h02)];
   assign frame_tick = (cnt_r == slot_cur - 24'h000001) && ({1'b0, slot_r} == MEMBERS - 5'h01);
   assign tmo        = SHORT_TMO ? `TMO_SHORT_FRAMES : `TMO_LONG_FRAMES;
   assign ent        = entry_t'(air.p_data);
   assign rx_hit     = air.p_valid && (air.p_chan == air.n_chan);
   assign join_ev    = commit_r && stg_vld_r[0] && (stg_age_r[0] < tmo);
   assign drop_ev    = (st_r == ST_RUN) && (NODE_IDX != 4'h0) && !fresh[0];
   assign tx_go      = (st_r == ST_RUN) && (cnt_r == 24'h000000) && (slot_r == NODE_IDX) && (tx_st_r == TX_IDLE);

   // Link state: node one never scans, others join on node-one data
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
         st_r <= ST_SCAN;
      else
         case (st_r)
            ST_SCAN: if (NODE_IDX == 4'h0 || join_ev) st_r <= ST_RUN;
            ST_RUN:  if (drop_ev) st_r <= ST_SCAN;
            default: st_r <= ST_SCAN;
         endcase
   end

   // Slot timer; members resync to each accepted packet, node one is the time master
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cnt_r  <= 24'h000000;
         slot_r <= 4'h0;
      end
      else if (commit_r && NODE_IDX != 4'h0)
      begin
         cnt_r  <= 24'h000001;
         slot_r <= rx_src_r;
      end
      else if (cnt_r == slot_cur - 24'h000001)
      begin
         cnt_r  <= 24'h000000;
         slot_r <= frame_tick ? 4'h0 : slot_r + 4'h1;
      end
      else
         cnt_r <= cnt_r + 24'h000001;
   end

   // Channel scan and radio channel selection
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         scan_cnt_r <= 32'h00000000;
         scan_ch_r  <= 4'h0;
         air.n_chan <= `IEEE_CH_FIRST;
      end
      else
      begin
         if (st_r == ST_SCAN && scan_cnt_r == 32'(SCAN_DWELL_CYC - 1))
         begin
            scan_cnt_r <= 32'h00000000;
            scan_ch_r  <= scan_ch_r + 4'h1;
         end
         else if (st_r == ST_SCAN)
            scan_cnt_r <= scan_cnt_r + 32'h00000001;
         air.n_chan <= (st_r == ST_RUN) ? CHANNEL + `IEEE_CH_OFFSET
                                        : {1'b0, scan_ch_r} + `IEEE_CH_FIRST;
      end
   end

   // Receive: header and serial filter, stage entries, commit only on good checksum
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rx_ph_r   <= 2'h0;
         rx_ok_r   <= 1'b0;
         rx_src_r  <= 4'h0;
         commit_r  <= 1'b0;
         stg_vld_r <= 16'h0000;
         stg_sig_r <= '0;
         stg_age_r <= '0;
      end
      else
      begin
         commit_r <= 1'b0;
         if (rx_hit && air.p_sop)
         begin
            rx_ph_r   <= 2'h1;
            rx_src_r  <= air.p_data[`HDR_SRC_MSB:`HDR_SRC_LSB];
            stg_vld_r <= 16'h0000;
            rx_ok_r   <= (air.p_data[`HDR_PROG_MSB:`HDR_PROG_LSB] == PROG_ID) &&
                         ({1'b0, air.p_data[`HDR_SRC_MSB:`HDR_SRC_LSB]} < MEMBERS) &&
                         (air.p_data[`HDR_SRC_MSB:`HDR_SRC_LSB] != NODE_IDX);
         end
         else if (rx_hit && rx_ph_r == 2'h1)
         begin
            rx_ph_r <= 2'h2;
            rx_ok_r <= rx_ok_r && (air.p_data == MEMBER_SERIAL[rx_src_r]);
         end
         else if (rx_hit && rx_ph_r == 2'h2 && air.p_eop)
         begin
            rx_ph_r  <= 2'h0;
            commit_r <= rx_ok_r && (air.p_data == rx_crc);
         end
         else if (rx_hit && rx_ph_r == 2'h2 && ({1'b0, ent.origin} < MEMBERS) && ent.origin != NODE_IDX)
         begin
            stg_vld_r[ent.origin] <= 1'b1;
            stg_sig_r[ent.origin] <= ent.sig;
            stg_age_r[ent.origin] <= ent.age;
         end
      end
   end

   frame_crc32 u_rx_crc
   (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .start (air.p_sop),
      .en    (rx_hit && !air.p_eop),
      .din   (air.p_data),
      .crc_r (rx_crc)
   );

   // Per-source table, freshness and safe-state latch
   for (genvar g = 0; g < 16; g++)
   begin : g_src
      assign fresh[g] = tbl_vld_r[g] && (tbl_age_r[g] < tmo);

      always_ff @(posedge REF_CLK or negedge RST_B)
      begin
         if (!RST_B)
         begin
            tbl_vld_r[g] <= 1'b0;
            tbl_age_r[g] <= `AGE_SAT;
            tbl_sig_r[g] <= 16'h0000;
         end
         else if (drop_ev)
            tbl_vld_r[g] <= 1'b0;
         else if (commit_r && stg_vld_r[g] && (!fresh[g] || stg_age_r[g] < tbl_age_r[g]))
         begin
            tbl_vld_r[g] <= 1'b1;
            tbl_age_r[g] <= stg_age_r[g];
            tbl_sig_r[g] <= stg_sig_r[g];
         end
         else if (frame_tick && tbl_age_r[g] != `AGE_SAT)
            tbl_age_r[g] <= tbl_age_r[g] + 8'h01;
      end

      // A loss sets the latch even in a restart cycle; only restart clears it
      always_ff @(posedge REF_CLK or negedge RST_B)
      begin
         if (!RST_B)
         begin
            fresh_r[g] <= 1'b0;
            lost_r[g]  <= 1'b0;
            RX_SIG[g]  <= 16'h0000;
            RX_OK[g]   <= 1'b0;
         end
         else
         begin
            fresh_r[g] <= fresh[g];
            lost_r[g]  <= (lost_r[g] && !RESTART) || (fresh_r[g] && !fresh[g]);
            RX_OK[g]   <= fresh[g] && !lost_r[g];
            RX_SIG[g]  <= (fresh[g] && !lost_r[g]) ? tbl_sig_r[g] : 16'h0000;
         end
      end
   end

   // Transmit word selection: own item at age zero, relays with their age
   always_comb
   begin
      tx_load = 1'b0;
      tx_sop  = 1'b0;
      tx_eop  = 1'b0;
      tx_word = 32'h00000000;
      case (tx_st_r)
         TX_HDR:
         begin
            tx_load = 1'b1;
            tx_sop  = 1'b1;
            tx_word = {PROG_ID, 12'h000, NODE_IDX};
         end
         TX_SER:
         begin
            tx_load = 1'b1;
            tx_word = MEMBER_SERIAL[NODE_IDX];
         end
         TX_ENT:
         begin
            if (tx_idx_r == NODE_IDX)
            begin
               tx_load = 1'b1;
               tx_word = {tx_idx_r, 8'h00, 4'h0, own_r};
            end
            else if (fresh[tx_idx_r])
            begin
               tx_load = 1'b1;
               tx_word = {tx_idx_r, tbl_age_r[tx_idx_r], 4'h0, tbl_sig_r[tx_idx_r]};
            end
         end
         TX_CRC:
         begin
            tx_load = 1'b1;
            tx_eop  = 1'b1;
            tx_word = tx_crc;
         end
         default: tx_load = 1'b0;
      endcase
   end

   // Transmit sequencing; fire and forget, nothing waits for a reply
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tx_st_r     <= TX_IDLE;
         tx_idx_r    <= 4'h0;
         own_r       <= 16'h0000;
         air.n_valid <= 1'b0;
         air.n_sop   <= 1'b0;
         air.n_eop   <= 1'b0;
         air.n_data  <= 32'h00000000;
      end
      else
      begin
         air.n_valid <= tx_load;
         air.n_sop   <= tx_sop;
         air.n_eop   <= tx_eop;
         air.n_data  <= tx_word;
         case (tx_st_r)
            TX_IDLE: if (tx_go)
                     begin
                        tx_st_r <= TX_HDR;
                        own_r   <= OWN_SIG;
                     end
            TX_HDR:  tx_st_r <= TX_SER;
            TX_SER:
            begin
               tx_st_r  <= TX_ENT;
               tx_idx_r <= 4'h0;
            end
            TX_ENT:
            begin
               tx_idx_r <= tx_idx_r + 4'h1;
               if ({1'b0, tx_idx_r} == MEMBERS - 5'h01)
                  tx_st_r <= TX_CRC;
            end
            TX_CRC:  tx_st_r <= TX_IDLE;
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   frame_crc32 u_tx_crc
   (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .start (tx_sop),
      .en    (tx_load && !tx_eop),
      .din   (tx_word),
      .crc_r (tx_crc)
   );

   // Join status
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
         JOINED <= 1'b0;
      else
         JOINED <= (st_r == ST_RUN);
   end

endmodule // safety_frame_node

// >>> pkg/radio_frame_cfg.svh
// Constants of the radio safety frame sequencer: layouts, codes and timing
`ifndef RADIO_FRAME_CFG_SVH
`define RADIO_FRAME_CFG_SVH

`define REF_CLK_MHZ      50
`define MAX_NODES        16
`define SIG_W            16
`define AGE_W            8
`define AGE_SAT          8'hff
// Configured channel 1..16 plus this offset gives the 802.15.4 channel 11..26
`define IEEE_CH_OFFSET   5'h0a
`define IEEE_CH_FIRST    5'h0b
// Frame time in microseconds for 2..16 members
`define FRAME_US_TABLE   '{4250, 6380, 8500, 11250, 13880, 16630, 20000, 23060, 26250, \
                           29560, 33750, 37380, 41130, 45940, 50000}
// Dwell per channel while scanning, in microseconds
`define SCAN_DWELL_US    20000
// Long and short timeouts, in frames
`define TMO_LONG_FRAMES  8'h28
`define TMO_SHORT_FRAMES 8'h0a
// Header word: program id in 31:16, sender index in 3:0
`define HDR_PROG_MSB     31
`define HDR_PROG_LSB     16
`define HDR_SRC_MSB      3
`define HDR_SRC_LSB      0
`define CRC_POLY         32'h04c11db7
`define CRC_INIT         32'hffffffff

`endif

// >>> pkg/radio_frame_pkg.sv
// Types shared by both ends of the radio safety link
package radio_frame_pkg;

   // One relayed item: origin node, age in frames, signals
   typedef struct packed {
      logic [3:0]  origin;
      logic [7:0]  age;
      logic [3:0]  spare;
      logic [15:0] sig;
   } entry_t;

   typedef enum logic [1:0] {
      ST_SCAN = 2'b00,
      ST_RUN  = 2'b01
   } link_st_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_HDR  = 3'b001,
      TX_SER  = 3'b010,
      TX_ENT  = 3'b011,
      TX_CRC  = 3'b100
   } tx_st_t;

endpackage

// >>> pkg/radio_air_if.sv
// Shared air medium between the sequencer node and a peer node
`timescale 1ns/1ps
interface radio_air_if;
   // Sequencer node transmit
   logic        n_valid;
   logic        n_sop;
   logic        n_eop;
   logic [31:0] n_data;
   logic [4:0]  n_chan;
   // Peer node transmit
   logic        p_valid;
   logic        p_sop;
   logic        p_eop;
   logic [31:0] p_data;
   logic [4:0]  p_chan;

   modport node (output n_valid, n_sop, n_eop, n_data, n_chan,
                 input  p_valid, p_sop, p_eop, p_data, p_chan);
   modport peer (output p_valid, p_sop, p_eop, p_data, p_chan,
                 input  n_valid, n_sop, n_eop, n_data, n_chan);
endinterface

// >>> hw/frame_crc32.sv
// Word-serial CRC-32 accumulator used by both transmit and receive paths
`timescale 1ns/1ps
`include "radio_frame_cfg.svh"
module frame_crc32
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Word feed
   input  wire logic        start,
   input  wire logic        en,
   input  wire logic [31:0] din,
   // Running checksum
   output logic      [31:0] crc_r
);

   // Shift one word through the polynomial, MSB first
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 31; i >= 0; i--)
      begin
         r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ `CRC_POLY) : {r[30:0], 1'b0};
      end
      return r;
   endfunction

   // A start word restarts from the seed so no state leaks between packets
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         crc_r <= `CRC_INIT;
      else if (en)
         crc_r <= crc_step(start ? `CRC_INIT : crc_r, din);
   end

endmodule // frame_crc32

// >>> hw/peer_node_end.sv
// Simple peer node: sends its own item on request after its predecessor, checks what it hears
`timescale 1ns/1ps
`include "radio_frame_cfg.svh"
module peer_node_end
   import radio_frame_pkg::*;
(
   // Clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              RST_B,
   // Configuration
   input  wire logic [3:0]        NODE_IDX,
   input  wire logic [4:0]        MEMBERS,
   input  wire logic [4:0]        CHANNEL,
   input  wire logic [15:0]       PROG_ID,
   input  wire logic [15:0][31:0] MEMBER_SERIAL,
   // Send request
   input  wire logic              SEND,
   input  wire logic [15:0]       OWN_SIG,
   output logic                   BUSY,
   // Received sender item
   output logic                   RX_STB,
   output logic      [3:0]        RX_SRC,
   output logic      [15:0]       RX_SIG,
   // Air
   radio_air_if.peer              air
);

   tx_st_t      tx_st_r;
   logic        pred_r;
   logic [1:0]  rx_ph_r;
   logic        rx_ok_r;
   logic [3:0]  rx_src_r;
   logic [15:0] rx_sig_r;
   logic        rx_hit;
   logic [31:0] rx_crc;
   logic [31:0] tx_crc;
   logic [31:0] tx_word;
   entry_t      ent;

   assign ent    = entry_t'(air.n_data);
   assign rx_hit = air.n_valid && (air.n_chan == CHANNEL + `IEEE_CH_OFFSET);

   // Transmit word for each step; no reply is ever expected
   always_comb
   begin
      case (tx_st_r)
         TX_HDR:  tx_word = {PROG_ID, 12'h000, NODE_IDX};
         TX_SER:  tx_word = MEMBER_SERIAL[NODE_IDX];
         TX_ENT:  tx_word = {NODE_IDX, 8'h00, 4'h0, OWN_SIG};
         TX_CRC:  tx_word = tx_crc;
         default: tx_word = 32'h00000000;
      endcase
   end

   // Send only as node one or once the predecessor was heard, keeping ascending order
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tx_st_r     <= TX_IDLE;
         BUSY        <= 1'b0;
         air.p_valid <= 1'b0;
         air.p_sop   <= 1'b0;
         air.p_eop   <= 1'b0;
         air.p_data  <= 32'h00000000;
         air.p_chan  <= `IEEE_CH_FIRST;
      end
      else
      begin
         air.p_chan  <= CHANNEL + `IEEE_CH_OFFSET;
         air.p_valid <= (tx_st_r != TX_IDLE);
         air.p_sop   <= (tx_st_r == TX_HDR);
         air.p_eop   <= (tx_st_r == TX_CRC);
         air.p_data  <= tx_word;
         case (tx_st_r)
            TX_IDLE: if (SEND && (NODE_IDX == 4'h0 || pred_r)) tx_st_r <= TX_HDR;
            TX_HDR:  tx_st_r <= TX_SER;
            TX_SER:  tx_st_r <= TX_ENT;
            TX_ENT:  tx_st_r <= TX_CRC;
            default: tx_st_r <= TX_IDLE;
         endcase
         BUSY <= (tx_st_r == TX_IDLE) ? (SEND && (NODE_IDX == 4'h0 || pred_r)) : (tx_st_r != TX_CRC);
      end
   end

   frame_crc32 u_tx_crc
   (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .start (tx_st_r == TX_HDR),
      .en    (tx_st_r != TX_IDLE && tx_st_r != TX_CRC),
      .din   (tx_word),
      .crc_r (tx_crc)
   );

   // Receive: program, member and checksum checks before any item is shown
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rx_ph_r  <= 2'h0;
         rx_ok_r  <= 1'b0;
         rx_src_r <= 4'h0;
         rx_sig_r <= 16'h0000;
         pred_r   <= 1'b0;
         RX_STB   <= 1'b0;
         RX_SRC   <= 4'h0;
         RX_SIG   <= 16'h0000;
      end
      else
      begin
         RX_STB <= 1'b0;
         if (rx_hit && air.n_sop)
         begin
            rx_ph_r  <= 2'h1;
            rx_src_r <= air.n_data[`HDR_SRC_MSB:`HDR_SRC_LSB];
            rx_ok_r  <= (air.n_data[`HDR_PROG_MSB:`HDR_PROG_LSB] == PROG_ID) &&
                        ({1'b0, air.n_data[`HDR_SRC_MSB:`HDR_SRC_LSB]} < MEMBERS);
         end
         else if (rx_hit && rx_ph_r == 2'h1)
         begin
            rx_ph_r <= 2'h2;
            rx_ok_r <= rx_ok_r && (air.n_data == MEMBER_SERIAL[rx_src_r]);
         end
         else if (rx_hit && rx_ph_r == 2'h2 && air.n_eop)
         begin
            rx_ph_r <= 2'h0;
            if (rx_ok_r && air.n_data == rx_crc)
            begin
               RX_STB <= 1'b1;
               RX_SRC <= rx_src_r;
               RX_SIG <= rx_sig_r;
            end
         end
         else if (rx_hit && rx_ph_r == 2'h2 && ent.origin == rx_src_r)
            rx_sig_r <= ent.sig;
         // A predecessor packet sets the permit even while a send starts
         if (rx_hit && rx_ph_r == 2'h2 && air.n_eop && rx_ok_r && air.n_data == rx_crc &&
             rx_src_r == NODE_IDX - 4'h1)
            pred_r <= 1'b1;
         else if (tx_st_r == TX_HDR)
            pred_r <= 1'b0;
      end
   end

   frame_crc32 u_rx_crc
   (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .start (air.n_sop),
      .en    (rx_hit && !air.n_eop),
      .din   (air.n_data),
      .crc_r (rx_crc)
   );

endmodule // peer_node_end

// >>> verification/radio_air_properties.sv
// Air-side checks on the node and peer link
`timescale 1ns/1ps
module radio_air_properties
#(
   parameter int FRAME_CYC = 400
)
(
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   // Node transmit
   input  wire logic        n_valid,
   input  wire logic        n_sop,
   input  wire logic        n_eop,
   input  wire logic [31:0] n_data,
   input  wire logic [4:0]  n_chan,
   // Peer transmit
   input  wire logic        p_valid,
   input  wire logic        p_sop,
   input  wire logic        p_eop,
   input  wire logic [31:0] p_data,
   input  wire logic [4:0]  p_chan
);
   logic [15:0] gap_r;
   logic        heard_r;
   logic [15:0] prog_r;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // Gap since last node packet; saturates so the first packet is never flagged
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B) gap_r <= 16'hffff;
      else if (n_sop) gap_r <= 16'h0000;
      else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
   // Peer may only speak after hearing its predecessor
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B) heard_r <= 1'b0;
      else if (n_eop) heard_r <= 1'b1;
      else if (p_sop) heard_r <= 1'b0;
   // Program id last sent by the node
   always_ff @(posedge REF_CLK or negedge RST_B)
      if (!RST_B) prog_r <= 16'h0000;
      else if (n_sop) prog_r <= n_data[31:16];
   a_chan_range: assert property (n_valid |-> n_chan >= 5'h0b && n_chan <= 5'h1a)
      else $error("node channel out of range");
   a_chan_pair: assert property (p_valid |-> p_chan == n_chan)
      else $error("channels differ");
   a_node_shape: assert property (n_sop |-> n_valid ##4 (n_valid && n_eop))
      else $error("node packet length wrong");
   a_eop_alone: assert property (n_eop |-> n_valid && !n_sop)
      else $error("node end word malformed");
   a_node_spacing: assert property (n_sop |-> gap_r >= FRAME_CYC / 4)
      else $error("node packet repeated too soon");
   a_hdr_format: assert property (n_sop |-> n_data[15:4] == 12'h000)
      else $error("node header malformed");
   a_prog_match: assert property (p_sop |-> p_data[31:16] == prog_r)
      else $error("peer program differs");
   a_peer_permit: assert property (p_sop |-> heard_r)
      else $error("peer sent out of order");
   a_peer_shape: assert property (p_sop |=> (p_valid && !p_sop) [*3] ##0 p_eop)
      else $error("peer packet length wrong");
   a_own_age: assert property (p_sop |-> ##2 (p_data[27:20] == 8'h00 && p_data[31:28] == $past(p_data[3:0], 2)))
      else $error("own item age not zero");
endmodule // radio_air_properties

// >>> verification/radio_safety_frame_sequencer_tb_top.sv
// Bench: node one against a peer, plus a scanning node fed corrupt and clean packets
`timescale 1ns/1ps
`include "radio_frame_cfg.svh"
module radio_safety_frame_sequencer_tb_top;
   import radio_frame_pkg::*;
   localparam int unsigned FC = 400;
   localparam int unsigned FT [15] = '{15{FC}};
   logic              ref_clk;
   logic              rst_b;
   logic [4:0]        chan, mem;
   logic [15:0]       prog, own, psig, ok, ok2;
   logic [15:0][31:0] ser;
   logic              restart, tmo_s, send, busy, stb, joined, joined2;
   logic [3:0]        src, idx0, idx1;
   logic [15:0]       srx;
   logic [15:0][15:0] rx_sig, rx_sig2;
   logic [31:0]       exp_q [$];
   logic [31:0]       exp_last;
   int                err_total = 0, n_tests = 0, cyc = 0;
   radio_air_if air ();
   radio_air_if air2 ();
   safety_frame_node #(.CYC_PER_US(1), .FRAME_US(FT), .SCAN_DWELL_CYC(200)) safety_frame_node_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .NODE_IDX(idx0), .MEMBERS(mem), .CHANNEL(chan), .PROG_ID(prog),
      .MEMBER_SERIAL(ser), .SHORT_TMO(tmo_s), .OWN_SIG(own), .RESTART(restart), .RX_SIG(rx_sig), .RX_OK(ok),
      .JOINED(joined), .air(air.node));
   safety_frame_node #(.CYC_PER_US(1), .FRAME_US(FT), .SCAN_DWELL_CYC(200)) safety_frame_node_inst_b (
      .REF_CLK(ref_clk), .RST_B(rst_b), .NODE_IDX(idx1), .MEMBERS(mem), .CHANNEL(chan), .PROG_ID(prog),
      .MEMBER_SERIAL(ser), .SHORT_TMO(tmo_s), .OWN_SIG(own), .RESTART(restart), .RX_SIG(rx_sig2), .RX_OK(ok2),
      .JOINED(joined2), .air(air2.node));
   peer_node_end peer_node_end_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .NODE_IDX(idx1), .MEMBERS(mem), .CHANNEL(chan), .PROG_ID(prog),
      .MEMBER_SERIAL(ser), .SEND(send), .OWN_SIG(psig), .BUSY(busy), .RX_STB(stb), .RX_SRC(src),
      .RX_SIG(srx), .air(air.peer));
   radio_air_properties #(.FRAME_CYC(FC)) radio_air_properties_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .n_valid(air.n_valid), .n_sop(air.n_sop), .n_eop(air.n_eop),
      .n_data(air.n_data), .n_chan(air.n_chan), .p_valid(air.p_valid), .p_sop(air.p_sop),
      .p_eop(air.p_eop), .p_data(air.p_data), .p_chan(air.p_chan));
   // Free-running clock
   always #10 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         final_report();
      end
   end
   task automatic final_report();
      if (err_total == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Peer reports each node packet; last note repeats while own stands
   always @(negedge ref_clk)
   begin
      if (stb === 1'b1)
      begin
         if (exp_q.size() > 0)
            exp_last = exp_q.pop_front();
         check({12'h000, src, srx}, exp_last);
      end
   end
   // Step past the pulse once the monitor took its note
   task automatic wait_stb();
      while (stb !== 1'b1)
         @(negedge ref_clk);
      @(negedge ref_clk);
   endtask
   // Send is held until taken; table settles two edges after the crc word
   task automatic peer_send(input logic [15:0] v);
      psig = v;
      send = 1'b1;
      @(negedge ref_clk);
      while (busy !== 1'b1)
         @(negedge ref_clk);
      send = 1'b0;
      while (busy !== 1'b0)
         @(negedge ref_clk);
      repeat (4) @(negedge ref_clk);
   endtask
   // Node-one packet to the scanning node; bad flips the checksum
   task automatic air2_pkt(input logic [15:0] s, input logic bad);
      logic [31:0] w [3];
      logic [31:0] crc;
      w = '{{prog, 12'h000, 4'h0}, ser[0], {4'h0, 8'h00, 4'h0, s}};
      crc = `CRC_INIT;
      for (int i = 0; i < 3; i++)
      begin
         air2.p_valid = 1'b1;
         air2.p_sop = (i == 0);
         air2.p_data = w[i];
         for (int b = 31; b >= 0; b--)
            crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ w[i][b]) ? `CRC_POLY : 32'h0);
         @(negedge ref_clk);
      end
      air2.p_sop = 1'b0;
      air2.p_eop = 1'b1;
      air2.p_data = bad ? ~crc : crc;
      @(negedge ref_clk);
      air2.p_valid = 1'b0;
      air2.p_eop = 1'b0;
      air2.p_data = ~air2.p_data;
      repeat (4) @(negedge ref_clk);
   endtask
   // Main sequence
   initial
   begin
      logic [15:0] v;
      ref_clk = 1'b0;
      rst_b = 1'b0;
      restart = 1'b0;
      send = 1'b0;
      psig = 16'h0000;
      {air2.p_valid, air2.p_sop, air2.p_eop, air2.p_data} = '0;
      {idx0, idx1, mem, tmo_s} = {4'h0, 4'h1, 5'h02, 1'b1};
      void'($urandom(32'hbc418e69));
      chan = 5'h01 + 5'($urandom_range(15));
      air2.p_chan = chan + `IEEE_CH_OFFSET;
      prog = 16'($urandom);
      for (int i = 0; i < 16; i++)
         ser[i] = $urandom;
      own = 16'($urandom);
      exp_q.push_back({16'h0000, own});
      repeat (16) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      check({30'h0, joined, joined2}, 32'h2);
      check({16'h0, ok}, 32'h0);
      while (air2.n_chan !== chan + `IEEE_CH_OFFSET)
         @(negedge ref_clk);
      air2_pkt(16'hffff, 1'b1);
      check({15'h0, joined2, ok2}, 32'h0);
      air2_pkt(16'hffff, 1'b0);
      check({ok2, rx_sig2[0]}, 32'h0001ffff);
      check({31'h0, joined2}, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         wait_stb();
         check({27'h0, air.n_chan}, {27'h0, chan} + 32'h0a);
         v = 16'($urandom);
         own = v;
         exp_q.push_back({16'h0000, v});
         v = 16'($urandom);
         peer_send(v);
         check({ok, rx_sig[1]}, {16'h0002, v});
      end
      tmo_s = 1'b0;
      repeat (12 * FC) @(negedge ref_clk);
      check({ok, rx_sig[1]}, {16'h0002, v});
      tmo_s = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({ok, rx_sig[1]}, 32'h0);
      wait_stb();
      peer_send(16'h5a5a);
      check({ok, rx_sig[1]}, 32'h0);
      restart = 1'b1;
      @(negedge ref_clk);
      restart = 1'b0;
      wait_stb();
      peer_send(16'ha5a5);
      check({ok, rx_sig[1]}, 32'h0002a5a5);
      check({31'h0, joined2}, 32'h0);
      final_report();
   end
endmodule // radio_safety_frame_sequencer_tb_top
